/* File: include/sar_pkg.sv */
package sar_pkg;
  // Core clock rate and conversion window
  localparam int CLK_MHZ = 50;
  localparam int T_CONV_MIN_NS = 500;
  localparam int T_CONV_MAX_NS = 1600;
  // A least time rounds up, a longest time rounds down
  localparam int CONV_MIN_CYC = (T_CONV_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_MAX_CYC = (T_CONV_MAX_NS * CLK_MHZ) / 1000;
  // Result and frame lengths in serial clock falling edges
  localparam int RESULT_W = 16;
  localparam int FRAME_PLAIN = 16;
  localparam int FRAME_BUSY = 17;
  localparam int CNT_W = 5;
  localparam int CONV_CNT_W = 12;
  // Reset values
  localparam logic SYNC_RST = 1'b0;
  localparam logic CHIP_MODE_RST = 1'b1;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  // Controller states
  typedef enum logic [1:0] {SAR_SHDN, SAR_ACQ, SAR_CONV} sar_state_t;
endpackage : sar_pkg

/* File: src/sar_readout_ctrl.sv */
`timescale 1ns/1ns
module sar_readout_ctrl #(
  parameter int CONV_CYCLES = sar_pkg::CONV_MAX_CYC
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic SERIAL_CLK,
  input wire logic CONVERT_START_IN,
  input wire logic SERIAL_SELECT_IN,
  input wire logic [15:0] SAMPLE_CODE,
  output logic SERIAL_RESULT_OUT,
  output logic SERIAL_RESULT_OE,
  output logic SHUTDOWN_OUT
);

  // Clamp the conversion length into the legal window
  localparam int CONV_LEN = (CONV_CYCLES < sar_pkg::CONV_MIN_CYC) ? sar_pkg::CONV_MIN_CYC :
                            (CONV_CYCLES > sar_pkg::CONV_MAX_CYC) ? sar_pkg::CONV_MAX_CYC : CONV_CYCLES;
  localparam logic [sar_pkg::CONV_CNT_W-1:0] CONV_LOAD = sar_pkg::CONV_CNT_W'(CONV_LEN - 1);
  localparam logic [sar_pkg::CNT_W-1:0] LIM_PLAIN = sar_pkg::CNT_W'(sar_pkg::FRAME_PLAIN);
  localparam logic [sar_pkg::CNT_W-1:0] LIM_BUSY = sar_pkg::CNT_W'(sar_pkg::FRAME_BUSY);

  logic [2:0] pin_raw;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] sync3_ff;
  logic [2:0] lvl_ff;
  logic cnv_lvl;
  logic sel_lvl;
  logic sclk_lvl;
  logic cnv_prev_ff;
  logic sel_prev_ff;
  logic cnv_rise;
  logic cnv_fall;
  logic sel_rise;
  sar_pkg::sar_state_t st_ff;
  logic [sar_pkg::CONV_CNT_W-1:0] conv_cnt_ff;
  logic conv_done;
  logic chip_ff;
  logic chain_busy_ff;
  logic busy_ff;
  logic [15:0] sample_ff;
  logic [15:0] result_ff;
  logic ready_ff;
  logic rd_ff;
  logic rd_by_sel_ff;
  logic first_bit_ff;
  logic nxt_busy;
  logic both_low;
  logic rd_end;
  logic sclk_rst;
  logic [sar_pkg::CNT_W-1:0] cnt_ff;
  logic [sar_pkg::CNT_W-1:0] limit;
  logic sdo_bit_ff;
  logic [15:0] chain_ff;

  // Picks the frame bit for a given falling-edge position
  function automatic logic frame_bit(input logic [sar_pkg::CNT_W-1:0] pos, input logic busy,
                                     input logic [15:0] word, input logic chained);
    logic [sar_pkg::CNT_W-1:0] p;
    p = pos - sar_pkg::CNT_W'(busy);
    if (busy && pos == '0) begin
      frame_bit = 1'b0;
    end else if (p < sar_pkg::CNT_W'(sar_pkg::RESULT_W)) begin
      frame_bit = word[4'(sar_pkg::RESULT_W - 1) - p[3:0]];
    end else begin
      frame_bit = chained;
    end
  endfunction : frame_bit

  // Pin inputs pass three flops; a level counts once stages two and three agree
  assign pin_raw = {SERIAL_CLK, SERIAL_SELECT_IN, CONVERT_START_IN};
  genvar g;
  for (g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
        sync1_ff[g] <= sar_pkg::SYNC_RST;
        sync2_ff[g] <= sar_pkg::SYNC_RST;
        sync3_ff[g] <= sar_pkg::SYNC_RST;
        lvl_ff[g] <= sar_pkg::SYNC_RST;
      end else begin
        sync1_ff[g] <= pin_raw[g];
        sync2_ff[g] <= sync1_ff[g];
        sync3_ff[g] <= sync2_ff[g];
        if (sync2_ff[g] == sync3_ff[g]) begin
          lvl_ff[g] <= sync3_ff[g];
        end
      end
    end
  end
  assign cnv_lvl = lvl_ff[0];
  assign sel_lvl = lvl_ff[1];
  assign sclk_lvl = lvl_ff[2];

  // Edge detection on the filtered levels
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cnv_prev_ff <= sar_pkg::SYNC_RST;
      sel_prev_ff <= sar_pkg::SYNC_RST;
    end else begin
      cnv_prev_ff <= cnv_lvl;
      sel_prev_ff <= sel_lvl;
    end
  end
  assign cnv_rise = cnv_lvl & ~cnv_prev_ff;
  assign cnv_fall = ~cnv_lvl & cnv_prev_ff;
  assign sel_rise = sel_lvl & ~sel_prev_ff;
  assign conv_done = (st_ff == sar_pkg::SAR_CONV) && (conv_cnt_ff == '0);
  assign nxt_busy = chip_ff ? (~cnv_lvl | ~sel_lvl) : chain_busy_ff;

  // Power and conversion sequencing
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st_ff <= sar_pkg::SAR_ACQ;
    end else begin
      case (st_ff)
        sar_pkg::SAR_SHDN: begin
          if (cnv_fall && !sclk_lvl) begin
            st_ff <= sar_pkg::SAR_ACQ;
          end
        end
        sar_pkg::SAR_ACQ: begin
          if (cnv_fall && sclk_lvl) begin
            st_ff <= sar_pkg::SAR_SHDN;
          end else if (cnv_rise) begin
            st_ff <= sar_pkg::SAR_CONV;
          end
        end
        sar_pkg::SAR_CONV: begin
          // ignores the start pin; returns to acquisition
          if (conv_done) begin
            st_ff <= sar_pkg::SAR_ACQ;
          end
        end
        default: begin
          st_ff <= sar_pkg::SAR_ACQ;
        end
      endcase
    end
  end
  assign SHUTDOWN_OUT = (st_ff == sar_pkg::SAR_SHDN);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      conv_cnt_ff <= '0;
    end else if (st_ff == sar_pkg::SAR_ACQ && cnv_rise && !(cnv_fall && sclk_lvl)) begin
      conv_cnt_ff <= CONV_LOAD;
    end else if (st_ff == sar_pkg::SAR_CONV && conv_cnt_ff != '0) begin
      conv_cnt_ff <= conv_cnt_ff - 1'b1;
    end
  end

  // mode latch at the start edge; chain busy follows the clock level there
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      chip_ff <= sar_pkg::CHIP_MODE_RST;
      chain_busy_ff <= 1'b0;
      sample_ff <= sar_pkg::RESULT_RST;
    end else if (st_ff == sar_pkg::SAR_ACQ && cnv_rise) begin
      chip_ff <= sel_lvl;
      chain_busy_ff <= sclk_lvl;
      sample_ff <= SAMPLE_CODE;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      result_ff <= sar_pkg::RESULT_RST;
      busy_ff <= 1'b0;
      first_bit_ff <= 1'b0;
    end else if (conv_done) begin
      result_ff <= sample_ff;
      busy_ff <= nxt_busy;
      first_bit_ff <= nxt_busy ? 1'b0 : sample_ff[sar_pkg::RESULT_W-1];
    end
  end

  // Readout window; the frame is closed by a start rise or, in 4-wire, by select rising
  assign rd_end = cnv_rise || (rd_by_sel_ff && sel_rise);
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rd_ff <= 1'b0;
      rd_by_sel_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else if (conv_done) begin
      ready_ff <= 1'b1;
      // busy and chain frames open at completion
      rd_ff <= nxt_busy || !chip_ff;
      rd_by_sel_ff <= chip_ff && cnv_lvl;
    end else if (rd_end) begin
      // early release on a start rise
      rd_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else if (ready_ff && !rd_ff && chip_ff && (cnv_lvl ^ sel_lvl)) begin
      rd_ff <= 1'b1;
      rd_by_sel_ff <= cnv_lvl;
    end
  end

  // Serial side: counter held clear outside the frame, so a stopped clock is harmless
  assign sclk_rst = RESET | ~rd_ff;
  assign limit = busy_ff ? LIM_BUSY : LIM_PLAIN;
  always_ff @(negedge SERIAL_CLK or posedge sclk_rst) begin
    if (sclk_rst) begin
      cnt_ff <= '0;
    end else if (cnt_ff != limit) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // next bit on each falling edge; result_ff is quiet for the whole frame
  always_ff @(negedge SERIAL_CLK or posedge sclk_rst) begin
    if (sclk_rst) begin
      sdo_bit_ff <= 1'b0;
    end else begin
      sdo_bit_ff <= frame_bit(cnt_ff + 1'b1, busy_ff, result_ff, chain_ff[15]);
    end
  end

  // chain shifting: upstream data appears after this part's own word
  always_ff @(negedge SERIAL_CLK or posedge RESET) begin
    if (RESET) begin
      chain_ff <= sar_pkg::RESULT_RST;
    end else begin
      chain_ff <= {chain_ff[14:0], SERIAL_SELECT_IN};
    end
  end

  // in chip mode, both low forces a driven low
  assign both_low = chip_ff && !cnv_lvl && !sel_lvl;
  // bit changes only on falling edges, so it is stable at the rising one
  assign SERIAL_RESULT_OUT = both_low ? 1'b0 : ((cnt_ff == '0) ? first_bit_ff : sdo_bit_ff);
  // chip modes release at the frame limit and while converting, unless both pins are low; chain mode always drives
  assign SERIAL_RESULT_OE = !chip_ff || both_low || (rd_ff && cnt_ff != limit);

  property p_shdn_enter;
    @(posedge CLK) disable iff (RESET)
    (st_ff == sar_pkg::SAR_ACQ && cnv_fall && sclk_lvl) |=> SHUTDOWN_OUT ##1 SHUTDOWN_OUT;
  endproperty
  a_shdn_enter: assert property (p_shdn_enter) else $error("shutdown not entered");

  property p_wake;
    @(posedge CLK) disable iff (RESET)
    (SHUTDOWN_OUT && cnv_fall && !sclk_lvl) |=> !SHUTDOWN_OUT;
  endproperty
  a_wake: assert property (p_wake) else $error("shutdown not left");

  property p_start;
    @(posedge CLK) disable iff (RESET)
    (st_ff == sar_pkg::SAR_ACQ && cnv_rise && !sclk_lvl && sel_lvl && !rd_ff)
      |=> (st_ff == sar_pkg::SAR_CONV) && !SERIAL_RESULT_OE;
  endproperty
  a_start: assert property (p_start) else $error("conversion start wrong");

  property p_runs;
    @(posedge CLK) disable iff (RESET)
    (st_ff == sar_pkg::SAR_CONV && conv_cnt_ff > 1) |=> (st_ff == sar_pkg::SAR_CONV) [*2];
  endproperty
  a_runs: assert property (p_runs) else $error("conversion aborted");

  property p_result;
    @(posedge CLK) disable iff (RESET)
    conv_done |=> (result_ff == $past(sample_ff)) && ready_ff && (st_ff == sar_pkg::SAR_ACQ);
  endproperty
  a_result: assert property (p_result) else $error("result not loaded");

  property p_both_low;
    @(posedge CLK) disable iff (RESET)
    both_low |-> SERIAL_RESULT_OE && !SERIAL_RESULT_OUT;
  endproperty
  a_both_low: assert property (p_both_low) else $error("output not driven low");

  property p_busy_sel;
    @(posedge CLK) disable iff (RESET)
    (conv_done && chip_ff) |=> busy_ff == ($past(!cnv_lvl) || $past(!sel_lvl));
  endproperty
  a_busy_sel: assert property (p_busy_sel) else $error("busy decision wrong");

  property p_busy_low;
    @(posedge CLK) disable iff (RESET)
    (conv_done && chip_ff && nxt_busy) |=> rd_ff && SERIAL_RESULT_OE && !SERIAL_RESULT_OUT;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy bit not driven");

  property p_mode;
    @(posedge CLK) disable iff (RESET)
    (st_ff == sar_pkg::SAR_ACQ && cnv_rise) |=> chip_ff == $past(sel_lvl);
  endproperty
  a_mode: assert property (p_mode) else $error("mode latch wrong");

  property p_release;
    @(posedge CLK) disable iff (RESET)
    (chip_ff && rd_ff && !both_low && cnt_ff == limit) |-> !SERIAL_RESULT_OE;
  endproperty
  a_release: assert property (p_release) else $error("output not released");

  property p_early;
    @(posedge CLK) disable iff (RESET)
    (rd_ff && cnv_rise && !conv_done) |=> !rd_ff;
  endproperty
  a_early: assert property (p_early) else $error("frame not closed by start");

endmodule : sar_readout_ctrl

/* File: tb/sar_host_model.sv */
`timescale 1ns/1ns
// Host at the far side: drives the pins and the serial clock, sees a pulled-up data line
module sar_host_model (
  input wire logic CLK,
  input wire logic SERIAL_RESULT_OUT,
  input wire logic SERIAL_RESULT_OE,
  output logic CONVERT_START_IN,
  output logic SERIAL_SELECT_IN,
  output logic SERIAL_CLK
);
  logic line;
  // A released line floats up to the supply rail, never to the last bit
  assign line = SERIAL_RESULT_OE ? SERIAL_RESULT_OUT : 1'b1;
  initial begin
    CONVERT_START_IN = 1'b0;
    SERIAL_SELECT_IN = 1'b1;
    SERIAL_CLK = 1'b0;
  end
  // Pins move off the core edge and stay long enough to clear the input filter
  // clock level at fall
  task automatic pins(input logic st, input logic sel, input logic sck);
    @(negedge CLK);
    CONVERT_START_IN = st;
    SERIAL_SELECT_IN = sel;
    SERIAL_CLK = sck;
    repeat (6) @(negedge CLK);
  endtask : pins
  // Serial clock runs at 6 ns only inside a frame; bits are taken on the rising edge
  task automatic read_bits(input int n, output logic [16:0] word);
    word = 17'h0_0000;
    repeat (2) @(negedge CLK);
    for (int i = 0; i < n; i++) begin
      #3 SERIAL_CLK = 1'b1;
      word = {word[15:0], line};
      #3 SERIAL_CLK = 1'b0;
    end
  endtask : read_bits
endmodule : sar_host_model

/* File: tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
  localparam int CONV = 40;
  logic clk, reset, sclk, cnv, sel, out, oe, shdn;
  logic [15:0] code, c;
  logic [16:0] obs, word;
  logic [16:0] exp_q[$];
  event obs_ev;
  int mismatches, samples_checked, cycles;

  // Core clock, 20 ns
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  sar_readout_ctrl #(.CONV_CYCLES(CONV)) dut (.CLK(clk), .RESET(reset), .SERIAL_CLK(sclk),
    .CONVERT_START_IN(cnv), .SERIAL_SELECT_IN(sel), .SAMPLE_CODE(code),
    .SERIAL_RESULT_OUT(out), .SERIAL_RESULT_OE(oe), .SHUTDOWN_OUT(shdn));
  sar_host_model host (.CLK(clk), .SERIAL_RESULT_OUT(out), .SERIAL_RESULT_OE(oe),
    .CONVERT_START_IN(cnv), .SERIAL_SELECT_IN(sel), .SERIAL_CLK(sclk));

  task automatic check(input logic [16:0] seen, input logic [16:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check

  task automatic tally_and_finish;
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // Driver notes the expectation, the watcher pops it when the value shows
  task automatic note(input logic [16:0] expv, input logic [16:0] seen);
    exp_q.push_back(expv);
    obs = seen;
    -> obs_ev;
    #1;
  endtask : note

  always @(obs_ev) check(obs, exp_q.pop_front());

  // Shutdown flag, drive enable and line level seen through the pull-up
  function automatic logic [16:0] stat();
    return {14'h0000, shdn, oe, oe ? out : 1'b1};
  endfunction : stat

  // Chip-select start with a fresh random code; the line must let go
  task automatic start();
    c = 16'($urandom);
    @(negedge clk);
    code = c;
    host.pins(1'b0, 1'b1, 1'b0);
    host.pins(1'b1, 1'b1, 1'b0);
    note(17'h0_0001, stat());
  endtask : start

  task automatic wait_oe();
    for (int i = 0; i < 200 && oe !== 1'b1; i++) @(negedge clk);
  endtask : wait_oe

  // Read a frame and expect the line released after the last fall
  task automatic frame(input int n);
    host.read_bits(n, word);
    note({1'b0, c}, word);
    repeat (4) @(negedge clk);
    note(17'h0_0001, stat());
  endtask : frame

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    reset = 1'b1;
    code = 16'h0000;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    void'($urandom(32'ha7e5));
    repeat (6) @(negedge clk);
    note(17'h0_0001, stat());
    for (int r = 0; r < 2; r++) begin
      start();
      repeat (CONV + 10) @(negedge clk);
      note(17'h0_0001, stat());
      host.pins(1'b0, 1'b1, 1'b0);
      frame(16);
      start();
      host.pins(1'b0, 1'b1, 1'b0);
      wait_oe();
      note(17'h0_0002, stat());
      frame(17);
      start();
      host.pins(1'b1, 1'b0, 1'b0);
      wait_oe();
      note(17'h0_0002, stat());
      frame(17);
      host.pins(1'b1, 1'b1, 1'b0);
      start();
      repeat (CONV + 10) @(negedge clk);
      host.pins(1'b1, 1'b0, 1'b0);
      frame(16);
      host.pins(1'b1, 1'b1, 1'b0);
    end
    host.pins(1'b0, 1'b0, 1'b0);
    note(17'h0_0002, stat());
    // chain mode: select low at the start rise; frame opens by itself, output stays driven
    host.pins(1'b1, 1'b0, 1'b0);
    repeat (CONV + 10) @(negedge clk);
    host.read_bits(16, word);
    note({1'b0, c}, word);
    note(17'h0_0001, {16'h0000, oe});
    // Start low again so that the next rise is a fresh chip-select start
    host.pins(1'b0, 1'b0, 1'b0);
    host.pins(1'b1, 1'b1, 1'b1);
    repeat (CONV + 10) @(negedge clk);
    host.pins(1'b0, 1'b1, 1'b1);
    note(17'h0_0001, {16'h0000, shdn});
    host.pins(1'b1, 1'b1, 1'b0);
    note(17'h0_0001, {16'h0000, shdn});
    host.pins(1'b0, 1'b1, 1'b0);
    note(17'h0_0000, {16'h0000, shdn});
    tally_and_finish();
  end
endmodule : testbench
